/* dv/usart_status_and_irq_logic_tb.sv */
// self-checking bench for the status flag and interrupt mask block
// assumes the wishbone slave answers within a few clocks of a request
`timescale 1ns/100ps
module usart_status_and_irq_logic_tb;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        wbCyc   = 1'b0;
    logic        wbWe    = 1'b0;
    logic [7:0]  wbAdr   = 8'h00;
    logic [3:0]  wbSel   = 4'h0;
    logic [31:0] wbDatI  = 32'h0000_0000;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic [10:0] evt     = 11'h000;
    logic [3:0]  dma     = 4'h0;
    logic        shiftIdle = 1'b0;
    logic        sample16  = 1'b0;
    logic [2:0]  s16Cnt    = 3'h0;
    logic [3:0]  modemPins;
    logic        rxPin, rxLineOut, nakDrive, irq;
    logic [31:0] rdData;
    int          failCount = 0;
    int          numChecks = 0;
    int          naks;
    int          nakSeen;
    logic        rxEn, txEn, brkPend;

    always #5 clk_sys = ~clk_sys;
    // one sample enable every eight clocks
    always @(posedge clk_sys) begin
        s16Cnt   <= s16Cnt + 3'h1;
        sample16 <= (s16Cnt == 3'h7);
    end

    usirq_status #(.ITER_W(3)) dut (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .rxCharDone(evt[0]), .rxOverrun(evt[1]), .rxFrameErr(evt[2]),
        .rxParityErr(evt[3]), .rxBreak(evt[4]), .rxTimeout(evt[5]), .rxHoldRead(evt[6]),
        .txHoldLoaded(evt[7]), .txHoldTaken(evt[8]), .txShiftIdle(shiftIdle),
        .breakStarted(evt[9]), .nakDetected(evt[10]), .rxDmaDone(dma[0]),
        .txDmaDone(dma[1]), .txDmaBufferEmpty(dma[2]), .rxDmaBufferFull(dma[3]),
        .modemPins(modemPins), .rxPin(rxPin), .sample16(sample16), .rxLineOut(rxLineOut),
        .nakDrive(nakDrive), .rxEnabled(rxEn), .txEnabled(txEn), .breakPending(brkPend),
        .irq(irq));

    usirq_line_partner card (
        .clk_sys(clk_sys), .nakDrive(nakDrive), .modemPins(modemPins), .rxPin(rxPin),
        .nakCount(nakSeen));

    task automatic report_and_stop();
        if (failCount == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // classic cycle: hold the request until ack is sampled, then release
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk_sys);
        wbCyc  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbSel  <= 4'hf;
        wbDatI <= dat;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (wbAck !== 1'b1) begin
            failCount++;
            report_and_stop();
        end
        rdData = wbDatO;
        wbCyc <= 1'b0;
        wbWe  <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] adr, input logic [31:0] m,
                      input logic [31:0] exp);
        wb(1'b0, adr, 32'h0000_0000);
        chk(nm, exp, rdData & m);
    endtask
    task automatic cmd(input int b);
        wb(1'b1, usirq_pkg::OFS_CMD, 32'h0000_0001 << b);
    endtask
    // one-cycle event pulse, then time for flag and irq to settle
    task automatic pulse(input int b);
        @(posedge clk_sys);
        evt[b] <= 1'b1;
        @(posedge clk_sys);
        evt <= 11'h000;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        rd("mask view", usirq_pkg::OFS_IEN_VIEW, 32'hffff_ffff, 32'h0);
        rd("status", usirq_pkg::OFS_FLAGS, 32'hffff_ffff, 32'h0);
        rd("unmapped", 8'h3c, 32'hffff_ffff, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
    endtask
    task automatic t_mask();
        wb(1'b1, usirq_pkg::OFS_IEN_SET, 32'h000f_ffff);
        rd("mask all", usirq_pkg::OFS_IEN_VIEW, 32'hffff_ffff, 32'h000f_ffff);
        wb(1'b1, usirq_pkg::OFS_IEN_CLR, 32'h0000_0005);
        rd("mask cleared", usirq_pkg::OFS_IEN_VIEW, 32'hffff_ffff, 32'h000f_fffa);
        wb(1'b1, usirq_pkg::OFS_IEN_SET, 32'h0);
        wb(1'b1, usirq_pkg::OFS_IEN_VIEW, 32'hffff_ffff);
        rd("mask kept", usirq_pkg::OFS_IEN_VIEW, 32'hffff_ffff, 32'h000f_fffa);
        wb(1'b1, usirq_pkg::OFS_IEN_CLR, 32'hffff_ffff);
        rd("mask none", usirq_pkg::OFS_IEN_VIEW, 32'hffff_ffff, 32'h0);
    endtask
    task automatic t_errors();
        wb(1'b1, usirq_pkg::OFS_IEN_SET, 32'h0000_0020);
        naks = card.nakCount;
        for (int b = 1; b < 5; b++) pulse(b);
        chk("nak count", naks + 1, card.nakCount);
        rd("errors", usirq_pkg::OFS_FLAGS, 32'h0000_00e4, 32'h0000_00e4);
        chk("irq set", 32'h1, {31'h0, irq});
        cmd(usirq_pkg::CMD_CLR_ERR);
        rd("errors clr", usirq_pkg::OFS_FLAGS, 32'h0000_00e4, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("irq clr", 32'h0, {31'h0, irq});
        wb(1'b1, usirq_pkg::OFS_IEN_CLR, 32'hffff_ffff);
    endtask
    task automatic t_dma();
        logic [3:0] v [3] = '{4'h5, 4'ha, 4'h0};
        foreach (v[i]) begin
            dma <= v[i];
            rd("dma", usirq_pkg::OFS_FLAGS, 32'h0000_1818,
               {19'h0, v[i][3], v[i][2], 6'h0, v[i][1], v[i][0], 3'h0});
        end
    endtask
    task automatic t_rxtx();
        cmd(usirq_pkg::CMD_RX_ON);
        pulse(0);
        rd("rx ready", usirq_pkg::OFS_FLAGS, 32'h1, 32'h1);
        pulse(6);
        rd("rx read", usirq_pkg::OFS_FLAGS, 32'h1, 32'h0);
        pulse(0);
        cmd(usirq_pkg::CMD_RX_OFF);
        rd("rx off", usirq_pkg::OFS_FLAGS, 32'h1, 32'h0);
        cmd(usirq_pkg::CMD_RX_ON);
        rd("rx back", usirq_pkg::OFS_FLAGS, 32'h1, 32'h1);
        chk("rx enabled", 32'h1, {31'h0, rxEn});
        shiftIdle <= 1'b1;
        cmd(usirq_pkg::CMD_TX_ON);
        rd("tx on", usirq_pkg::OFS_FLAGS, 32'h202, 32'h202);
        pulse(7);
        rd("tx loaded", usirq_pkg::OFS_FLAGS, 32'h202, 32'h0);
        pulse(8);
        shiftIdle <= 1'b0;
        rd("tx shifting", usirq_pkg::OFS_FLAGS, 32'h202, 32'h002);
        shiftIdle <= 1'b1;
        cmd(usirq_pkg::CMD_BREAK);
        rd("tx break", usirq_pkg::OFS_FLAGS, 32'h2, 32'h0);
        chk("break pending", 32'h1, {31'h0, brkPend});
        pulse(9);
        cmd(usirq_pkg::CMD_TX_OFF);
        rd("tx off", usirq_pkg::OFS_FLAGS, 32'h202, 32'h0);
        chk("tx enabled", 32'h0, {31'h0, txEn});
    endtask
    task automatic t_misc();
        pulse(5);
        rd("timeout zero", usirq_pkg::OFS_FLAGS, 32'h100, 32'h0);
        wb(1'b1, usirq_pkg::OFS_TIMEOUT, 32'h0000_0005);
        cmd(usirq_pkg::CMD_ARM_TO);
        rd("timeout idle", usirq_pkg::OFS_FLAGS, 32'h100, 32'h0);
        pulse(5);
        rd("timeout", usirq_pkg::OFS_FLAGS, 32'h100, 32'h100);
        cmd(usirq_pkg::CMD_ARM_TO);
        rd("timeout armed", usirq_pkg::OFS_FLAGS, 32'h100, 32'h0);
        pulse(10);
        rd("nak seen", usirq_pkg::OFS_FLAGS, 32'h2000, 32'h2000);
        cmd(usirq_pkg::CMD_CLR_NAK);
        rd("nak clr", usirq_pkg::OFS_FLAGS, 32'h2000, 32'h0);
        card.set_modem(4'ha);
        repeat (8) @(posedge clk_sys);
        rd("modem", usirq_pkg::OFS_FLAGS, 32'h00ff_0000, 32'h00aa_0000);
        rd("modem again", usirq_pkg::OFS_FLAGS, 32'h00ff_0000, 32'h00a0_0000);
    endtask
    // three parity errors per mode; the t0 limit stops acknowledges after two, the suppress bit stops all
    task automatic t_card();
        logic [31:0] md [3] = '{32'h0220_0004, 32'h0220_0000, 32'h0010_0004};
        int          ex [3] = '{2, 3, 0};
        foreach (md[i]) begin
            wb(1'b1, usirq_pkg::OFS_MODE, md[i]);
            cmd(usirq_pkg::CMD_CLR_REP);
            naks = card.nakCount;
            repeat (3) pulse(3);
            chk("naks sent", naks + ex[i], card.nakCount);
            rd("repeat", usirq_pkg::OFS_FLAGS, 32'h400, (i == 0) ? 32'h400 : 32'h0);
        end
        wb(1'b1, usirq_pkg::OFS_MODE, md[0]);
        repeat (3) pulse(3);
        rd("repeat set", usirq_pkg::OFS_FLAGS, 32'h400, 32'h400);
        cmd(usirq_pkg::CMD_CLR_REP);
        rd("repeat clr", usirq_pkg::OFS_FLAGS, 32'h400, 32'h0);
    endtask
    // low span of n clocks right after a sample enable; one shorter than eight clocks covers at most one sample
    task automatic glitch(input logic [31:0] md, input int n, input logic exp);
        logic seen;
        int   guard;
        wb(1'b1, usirq_pkg::OFS_MODE, md);
        seen  = 1'b0;
        guard = 0;
        do begin
            @(posedge clk_sys);
            guard++;
        end while (sample16 !== 1'b1 && guard < 20);
        if (sample16 !== 1'b1) begin
            failCount++;
            report_and_stop();
        end
        fork
            card.hold_low(n);
            repeat (n + 30) begin
                @(posedge clk_sys);
                if (rxLineOut === 1'b0) seen = 1'b1;
            end
        join
        chk("line low", {31'h0, exp}, {31'h0, seen});
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_mask();
        t_errors();
        t_dma();
        t_rxtx();
        t_misc();
        t_card();
        glitch(32'h1000_0000, 6, 1'b0);
        glitch(32'h1000_0000, 40, 1'b1);
        glitch(32'h0000_0000, 6, 1'b1);
        report_and_stop();
    end
endmodule

/* dv/usirq_line_partner.sv */
// far-side model: modem control inputs, receive line, negative acknowledge counter
// assumes one clk_sys and one-cycle nakDrive pulses from the device
`timescale 1ns/100ps
module usirq_line_partner (
    input  wire logic       clk_sys,
    input  wire logic       nakDrive,
    output logic      [3:0] modemPins,
    output logic            rxPin,
    output int              nakCount
);
    // idle line rests high, as a pulled-up serial input would
    initial begin
        modemPins = 4'h0;
        rxPin     = 1'b1;
        nakCount  = 0;
    end
    // every acknowledge pulse the device drives counts once
    always @(posedge clk_sys) begin
        if (nakDrive === 1'b1) begin
            nakCount <= nakCount + 1;
        end
    end
    task automatic set_modem(input logic [3:0] v);
        @(posedge clk_sys);
        modemPins <= v;
    endtask
    // low pulse on the receive line, n clocks long
    task automatic hold_low(input int n);
        @(posedge clk_sys);
        rxPin <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rxPin <= 1'b1;
    endtask
endmodule

/* hw/usirq_pkg.sv */
// package for the serial status and interrupt mask block
// assumes a 32-bit classic wishbone slave on one clock
package usirq_pkg;
    localparam logic [7:0] OFS_CMD     = 8'h00;
    localparam logic [7:0] OFS_MODE    = 8'h04;
    localparam logic [7:0] OFS_IEN_SET = 8'h08;
    localparam logic [7:0] OFS_IEN_CLR = 8'h0c;
    localparam logic [7:0] OFS_IEN_VIEW= 8'h10;
    localparam logic [7:0] OFS_FLAGS   = 8'h14;
    localparam logic [7:0] OFS_TIMEOUT = 8'h24;
    // command bit positions
    localparam int CMD_RX_ON   = 4;
    localparam int CMD_RX_OFF  = 5;
    localparam int CMD_TX_ON   = 6;
    localparam int CMD_TX_OFF  = 7;
    localparam int CMD_CLR_ERR = 8;
    localparam int CMD_BREAK   = 9;
    localparam int CMD_ARM_TO  = 11;
    localparam int CMD_CLR_REP = 13;
    localparam int CMD_CLR_NAK = 14;
    // mode field positions
    localparam int MODE_LSB    = 0;
    localparam int SUPPRESS    = 20;
    localparam int LIMIT       = 21;
    localparam int ITER_LSB    = 24;
    localparam int FILT        = 28;
    localparam logic [3:0]  MODE_T0    = 4'h4;
    localparam logic [31:0] MODE_RST   = 32'h0000_0000;
    localparam logic [15:0] TO_RST     = 16'h0000;
    localparam logic [19:0] IEN_RST    = 20'h0_0000;
    // status bit positions
    localparam int F_RX_CHAR_AVAILABLE = 0;
    localparam int F_TX_HOLDING_FREE = 1;
    localparam int F_BRK   = 2;
    localparam int F_RX_DMA_DONE = 3;
    localparam int F_TX_DMA_DONE = 4;
    localparam int F_OVR   = 5;
    localparam int F_FRM   = 6;
    localparam int F_PAR   = 7;
    localparam int F_TO    = 8;
    localparam int F_TXE   = 9;
    localparam int F_ITER  = 10;
    localparam int F_TXBUF = 11;
    localparam int F_RXBUF = 12;
    localparam int F_NAK   = 13;
    localparam int F_MCHG  = 16;
    localparam int F_MLVL  = 20;
endpackage

/* hw/usirq_status.sv */
// status flags, interrupt mask and smart-card retry logic of a serial port
// assumes datapath event pulses and dma levels on clk_sys; modem and
// receive pins are asynchronous; sample16 is a one-cycle enable pulse
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/100ps
module usirq_status #(
    parameter int ITER_W = 3
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rxCharDone,
    input  wire logic        rxOverrun,
    input  wire logic        rxFrameErr,
    input  wire logic        rxParityErr,
    input  wire logic        rxBreak,
    input  wire logic        rxTimeout,
    input  wire logic        rxHoldRead,
    input  wire logic        txHoldLoaded,
    input  wire logic        txHoldTaken,
    input  wire logic        txShiftIdle,
    input  wire logic        breakStarted,
    input  wire logic        nakDetected,
    input  wire logic        rxDmaDone,
    input  wire logic        txDmaDone,
    input  wire logic        txDmaBufferEmpty,
    input  wire logic        rxDmaBufferFull,
    input  wire logic [3:0]  modemPins,
    input  wire logic        rxPin,
    input  wire logic        sample16,
    output logic             rxLineOut,
    output logic             nakDrive,
    output logic             rxEnabled,
    output logic             txEnabled,
    output logic             breakPending,
    output logic             irq
);
    logic [31:0] mode_reg;
    logic [15:0] toValue_reg;
    logic [19:0] ienMask_reg;
    logic        rxEn_reg, txEn_reg, brkPend_reg;
    logic        charSeen_reg, txFull_reg;
    logic        brk_reg, ovr_reg, frm_reg, par_reg, to_reg;
    logic        iter_reg, nak_reg;
    logic [ITER_W-1:0] iterCnt_reg;
    logic [3:0]  mSync1_reg, mSync2_reg, mPrev_reg, mChg_reg;
    logic        rxSync1_reg, rxSync2_reg;
    logic [2:0]  rxSamp_reg;
    logic        nak_next;
    logic [31:0] status;
    logic [31:0] rdData;
    logic        req, acc, wrAcc, rdFlags;
    logic [31:0] cmd;
    logic        clrErr, isT0;

    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    function automatic logic hit(input logic [7:0] ofs);
        return wb_adr_i == ofs;
    endfunction

    // bus request seen, access completes at the edge that samples ack
    assign req     = wb_cyc_i & wb_stb_i;
    assign acc     = req & wb_ack_o;
    assign wrAcc   = acc & wb_we_i;
    // change flags clear at the capture edge, so a change latched there is not lost
    assign rdFlags = req & ~wb_ack_o & ~wb_we_i & hit(usirq_pkg::OFS_FLAGS);
    assign cmd     = (wrAcc & hit(usirq_pkg::OFS_CMD)) ? wb_dat_i : 32'h0000_0000;
    assign clrErr  = cmd[usirq_pkg::CMD_CLR_ERR];
    assign isT0    = mode_reg[usirq_pkg::MODE_LSB +: 4] == usirq_pkg::MODE_T0;

    // one wait cycle: ack registered, drops after one cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    // combined status word
    always_comb begin
        status = 32'h0000_0000;
        status[usirq_pkg::F_RX_CHAR_AVAILABLE] = charSeen_reg & rxEn_reg;
        status[usirq_pkg::F_TX_HOLDING_FREE] = txEn_reg & ~txFull_reg & ~brkPend_reg;
        status[usirq_pkg::F_BRK]   = brk_reg;
        status[usirq_pkg::F_RX_DMA_DONE] = rxDmaDone;
        status[usirq_pkg::F_TX_DMA_DONE] = txDmaDone;
        status[usirq_pkg::F_OVR]   = ovr_reg;
        status[usirq_pkg::F_FRM]   = frm_reg;
        status[usirq_pkg::F_PAR]   = par_reg;
        status[usirq_pkg::F_TO]    = to_reg & (toValue_reg != 16'h0000);
        status[usirq_pkg::F_TXE]   = txEn_reg & ~txFull_reg & txShiftIdle;
        status[usirq_pkg::F_ITER]  = iter_reg;
        status[usirq_pkg::F_TXBUF] = txDmaBufferEmpty;
        status[usirq_pkg::F_RXBUF] = rxDmaBufferFull;
        status[usirq_pkg::F_NAK]   = nak_reg;
        status[usirq_pkg::F_MCHG +: 4] = mChg_reg;
        status[usirq_pkg::F_MLVL +: 4] = mSync2_reg;
    end

    // read mux, unmapped and write-only offsets read zero
    always_comb begin
        rdData = 32'h0000_0000;
        if (hit(usirq_pkg::OFS_MODE)) begin
            rdData = mode_reg;
        end else if (hit(usirq_pkg::OFS_IEN_VIEW)) begin
            rdData = {12'h000, ienMask_reg};
        end else if (hit(usirq_pkg::OFS_FLAGS)) begin
            rdData = status;
        end else if (hit(usirq_pkg::OFS_TIMEOUT)) begin
            rdData = {16'h0000, toValue_reg};
        end
    end

    // read data captured as ack rises, stable while ack high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req & ~wb_ack_o & ~wb_we_i) begin
            wb_dat_o <= rdData;
        end
    end

    // configuration registers with byte lanes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_reg    <= usirq_pkg::MODE_RST;
            toValue_reg <= usirq_pkg::TO_RST;
        end else if (wrAcc) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b] & hit(usirq_pkg::OFS_MODE)) begin
                    mode_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
                end
                if (wb_sel_i[b] & (b < 2) & hit(usirq_pkg::OFS_TIMEOUT)) begin
                    toValue_reg[8*(b%2) +: 8] <= wb_dat_i[8*(b%2) +: 8];
                end
            end
        end
    end

    // interrupt mask: set and clear act only on ones
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ienMask_reg <= usirq_pkg::IEN_RST;
        end else if (wrAcc & hit(usirq_pkg::OFS_IEN_SET)) begin
            ienMask_reg <= ienMask_reg | wb_dat_i[19:0];
        end else if (wrAcc & hit(usirq_pkg::OFS_IEN_CLR)) begin
            ienMask_reg <= ienMask_reg & ~wb_dat_i[19:0];
        end
    end

    // interrupt line registered from masked status
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status[19:0] & ienMask_reg);
        end
    end

    // enables; off wins when both are written together
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxEn_reg <= 1'b0;
            txEn_reg <= 1'b0;
        end else begin
            if (cmd[usirq_pkg::CMD_RX_OFF]) begin
                rxEn_reg <= 1'b0;
            end else if (cmd[usirq_pkg::CMD_RX_ON]) begin
                rxEn_reg <= 1'b1;
            end
            if (cmd[usirq_pkg::CMD_TX_OFF]) begin
                txEn_reg <= 1'b0;
            end else if (cmd[usirq_pkg::CMD_TX_ON]) begin
                txEn_reg <= 1'b1;
            end
        end
    end

    // character seen survives disable so it reappears on re-enable
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            charSeen_reg <= 1'b0;
        end else if (rxCharDone) begin
            charSeen_reg <= 1'b1;
        end else if (rxHoldRead) begin
            charSeen_reg <= 1'b0;
        end
    end

    // transmit holding occupancy and break request
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txFull_reg  <= 1'b0;
            brkPend_reg <= 1'b0;
        end else begin
            if (txHoldLoaded) begin
                txFull_reg <= 1'b1;
            end else if (txHoldTaken) begin
                txFull_reg <= 1'b0;
            end
            if (cmd[usirq_pkg::CMD_BREAK]) begin
                brkPend_reg <= 1'b1;
            end else if (breakStarted) begin
                brkPend_reg <= 1'b0;
            end
        end
    end

    // sticky receive errors; a new event beats the clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            brk_reg <= 1'b0;
            ovr_reg <= 1'b0;
            frm_reg <= 1'b0;
            par_reg <= 1'b0;
        end else begin
            brk_reg <= rxBreak | (brk_reg & ~clrErr);
            ovr_reg <= rxOverrun | (ovr_reg & ~clrErr);
            frm_reg <= rxFrameErr | (frm_reg & ~clrErr);
            par_reg <= rxParityErr | (par_reg & ~clrErr);
        end
    end

    // time-out and nak flags
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            to_reg  <= 1'b0;
            nak_reg <= 1'b0;
        end else begin
            to_reg  <= rxTimeout | (to_reg & ~cmd[usirq_pkg::CMD_ARM_TO]);
            nak_reg <= nakDetected | (nak_reg & ~cmd[usirq_pkg::CMD_CLR_NAK]);
        end
    end

    // negative acknowledge decision for a parity error
    always_comb begin
        nak_next = 1'b0;
        if (rxParityErr & ~mode_reg[usirq_pkg::SUPPRESS]) begin
            if (~mode_reg[usirq_pkg::LIMIT] | ~isT0) begin
                nak_next = 1'b1;
            end else begin
                nak_next = iterCnt_reg < mode_reg[usirq_pkg::ITER_LSB +: ITER_W];
            end
        end
    end

    // retry counter; a clean character ends the run of errors
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            iterCnt_reg <= '0;
            iter_reg    <= 1'b0;
            nakDrive    <= 1'b0;
        end else begin
            nakDrive <= nak_next;
            if (cmd[usirq_pkg::CMD_CLR_REP] | (rxCharDone & ~rxParityErr)) begin
                iterCnt_reg <= '0;
            end else if (nak_next & mode_reg[usirq_pkg::LIMIT]) begin
                iterCnt_reg <= iterCnt_reg + 1'b1;
            end
            if (rxParityErr & mode_reg[usirq_pkg::LIMIT] & isT0 & ~nak_next
                & ~mode_reg[usirq_pkg::SUPPRESS]) begin
                iter_reg <= 1'b1;
            end else if (cmd[usirq_pkg::CMD_CLR_REP]) begin
                iter_reg <= 1'b0;
            end
        end
    end

    // modem inputs synchronised, changes latched until status read
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mSync1_reg <= 4'h0;
            mSync2_reg <= 4'h0;
            mPrev_reg  <= 4'h0;
            mChg_reg   <= 4'h0;
        end else begin
            mSync1_reg <= modemPins;
            mSync2_reg <= mSync1_reg;
            mPrev_reg  <= mSync2_reg;
            // edge beats the read clear
            mChg_reg   <= (mSync2_reg ^ mPrev_reg) | (mChg_reg & {4{~rdFlags}});
        end
    end

    // receive line filter; adds up to two sample periods of latency
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxSync1_reg <= 1'b1;
            rxSync2_reg <= 1'b1;
            rxSamp_reg  <= 3'h7;
            rxLineOut   <= 1'b1;
        end else begin
            rxSync1_reg <= rxPin;
            rxSync2_reg <= rxSync1_reg;
            if (sample16) begin
                rxSamp_reg <= {rxSamp_reg[1:0], rxSync2_reg};
            end
            rxLineOut <= mode_reg[usirq_pkg::FILT] ? maj3(rxSamp_reg) : rxSync2_reg;
        end
    end

    assign rxEnabled    = rxEn_reg;
    assign txEnabled    = txEn_reg;
    assign breakPending = brkPend_reg;

    sequence seqParity;
        rxParityErr;
    endsequence
    sequence seqNakOut;
        ##1 nakDrive;
    endsequence

    AST_SUPPRESS_NAK: assert property (@(posedge clk_sys) disable iff (rst)
        seqParity and mode_reg[usirq_pkg::SUPPRESS] |-> ##1 !nakDrive)
        else $error("nak driven while suppressed");
    AST_PLAIN_NAK: assert property (@(posedge clk_sys) disable iff (rst)
        seqParity and !mode_reg[usirq_pkg::SUPPRESS] and !mode_reg[usirq_pkg::LIMIT]
        |-> seqNakOut)
        else $error("nak missing after parity error");
    AST_LIMIT_STOPS: assert property (@(posedge clk_sys) disable iff (rst)
        seqParity and mode_reg[usirq_pkg::LIMIT] and isT0 and !mode_reg[usirq_pkg::SUPPRESS]
        and iterCnt_reg >= mode_reg[usirq_pkg::ITER_LSB +: ITER_W]
        |-> ##1 (!nakDrive && iter_reg))
        else $error("limit not honoured");
    AST_MASK_SET: assert property (@(posedge clk_sys) disable iff (rst)
        wrAcc && hit(usirq_pkg::OFS_IEN_SET) |=> ienMask_reg == ($past(ienMask_reg)
        | $past(wb_dat_i[19:0])))
        else $error("enable set wrong");
    AST_MASK_CLR: assert property (@(posedge clk_sys) disable iff (rst)
        wrAcc && hit(usirq_pkg::OFS_IEN_CLR) |=> (ienMask_reg & $past(wb_dat_i[19:0])) == 20'h0)
        else $error("disable left bits set");
    AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
        |(status[19:0] & ienMask_reg) |=> irq)
        else $error("irq missing");
    AST_TX_HOLDING_FREE_LOW: assert property (@(posedge clk_sys) disable iff (rst)
        (txFull_reg || brkPend_reg || !txEn_reg) |-> !status[usirq_pkg::F_TX_HOLDING_FREE])
        else $error("tx ready while busy");
    AST_ERR_STICKY: assert property (@(posedge clk_sys) disable iff (rst)
        ovr_reg && !clrErr |=> ovr_reg)
        else $error("overrun dropped");
    AST_MODEM_CHG: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(mSync2_reg) |-> ##1 (mChg_reg != 4'h0))
        else $error("modem change missed");
    AST_TO_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        toValue_reg == 16'h0000 |-> !status[usirq_pkg::F_TO])
        else $error("timeout with zero value");

    // flag holding, clearing and pass-through checks
    AST_BRK_STICKY: assert property (@(posedge clk_sys) disable iff (rst)
        brk_reg && !clrErr |=> brk_reg)
        else $error("break flag dropped");
    AST_NAK_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
        nakDetected |=> nak_reg)
        else $error("nak flag missed");
    AST_ITER_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
        iter_reg && !cmd[usirq_pkg::CMD_CLR_REP] |=> iter_reg)
        else $error("repeat flag dropped");
    AST_RX_CHAR_AVAILABLE_OFF: assert property (@(posedge clk_sys) disable iff (rst)
        !rxEn_reg |-> !status[usirq_pkg::F_RX_CHAR_AVAILABLE])
        else $error("rx ready while receiver off");
    AST_TXE_OFF: assert property (@(posedge clk_sys) disable iff (rst)
        !txEn_reg |-> !status[usirq_pkg::F_TXE])
        else $error("tx empty while transmitter off");
    AST_FILTER_OFF: assert property (@(posedge clk_sys) disable iff (rst)
        !mode_reg[usirq_pkg::FILT] |=> rxLineOut == $past(rxSync2_reg))
        else $error("unfiltered line wrong");
    AST_MODEM_CLR: assert property (@(posedge clk_sys) disable iff (rst)
        rdFlags && (mSync2_reg == mPrev_reg) |=> mChg_reg == 4'h0)
        else $error("change flags kept after read");
endmodule
